// [design/ldo_regs_consts.svh]
// Offsets, reset values and voltage encoding constants for the regulator code bank
`ifndef LDO_REGS_CONSTS_SVH
`define LDO_REGS_CONSTS_SVH

// ****************************************************************
// Register pointers
// ****************************************************************
`define PTR_REG3_CODE     8'h07
`define PTR_REG4_CODE     8'h08
`define PTR_REG5_CODE     8'h09
`define PTR_SILICON_VER   8'h46

// ****************************************************************
// Reset values (fourth and fifth are variant dependent)
// ****************************************************************
`define RST_REG3_CODE     8'h11
`define RST_REG4_CODE     8'h16
`define RST_REG5_CODE     8'h02
`define RST_READ_DATA     8'h00

// ****************************************************************
// Version register fields
// ****************************************************************
`define VER_CODE_LSB      0
`define VER_CODE_MSB      1
`define VER_CODE_DEFAULT  2'h3

// ****************************************************************
// Voltage encoding, millivolts
// ****************************************************************
`define MV_BASE_REG3      16'h0640
`define MV_BASE_LOW       16'h0320
`define MV_STEP           16'h0064
`define TOP_CODE_REG3     8'h11
`define TOP_CODE_LOW      8'h19

`endif

// [design/ldo_regs_pkg.sv]
// Types shared by the regulator code bank
package ldo_regs_pkg;

    // Register access request, one cycle wide
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] ptr;
        logic [7:0] wdata;
    } reg_req_t;

    // Read answer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_t;

endpackage

// [design/code_to_mv.sv]
// Registered conversion of a regulator code to its output voltage in millivolts
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module code_to_mv #(
    parameter logic [15:0] BASE_MV = `MV_BASE_LOW
) (
    // Clock
    input  wire logic        clk_sys,
    // Code in, voltage out
    input  wire logic [7:0]  code,
    output logic      [15:0] volt_mv_r
);

    // Base plus one step per code, registered
    always_ff @(posedge clk_sys) begin
        volt_mv_r <= 16'(BASE_MV + 16'({8'h00, code} * `MV_STEP));
    end

endmodule

// [design/ldo_voltage_and_version_regs.sv]
// Regulator output voltage code registers and silicon version register
//
// Overview of operation
// - Third regulator code register, read/write at pointer 0x07, resets to 0x11.
// - Third code is linear: 0x00 gives 1.6V, plus 0.1V per step to 3.3V.
// - Fourth code register at 0x08, 0.8V plus 0.1V steps, variant reset value.
// - Fifth code register at 0x09, same encoding, variant dependent reset value.
// - Read-only version register at 0x46, low two bits give hard-wired variant code.
// - Version bits 7 to 2 are reserved; host must not rely on them.
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module ldo_voltage_and_version_regs #(
    parameter logic [7:0] REG4_RESET   = `RST_REG4_CODE,    // 0x16 or 0x19 by variant
    parameter logic [7:0] REG5_RESET   = `RST_REG5_CODE,    // 0x02, 0x14 or 0x16
    parameter logic [1:0] VERSION_CODE = `VER_CODE_DEFAULT  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // Register access from the serial interface
    input  wire ldo_regs_pkg::reg_req_t   req,
    output ldo_regs_pkg::reg_rsp_t        rsp_r,
    // Regulator codes
    output logic                [7:0]     third_regulator_code,
    output logic                [7:0]     fourth_regulator_code,
    output logic                [7:0]     fifth_regulator_code,
    // Regulator target voltages in millivolts
    output logic                [15:0]    third_regulator_mv,
    output logic                [15:0]    fourth_regulator_mv,
    output logic                [15:0]    fifth_regulator_mv
);

    // ****************************************************************
    // Code registers
    // ****************************************************************
    localparam logic [2:0][7:0]  PTRS  = {`PTR_REG5_CODE, `PTR_REG4_CODE, `PTR_REG3_CODE};
    localparam logic [2:0][7:0]  RSTS  = {REG5_RESET, REG4_RESET, `RST_REG3_CODE};
    localparam logic [2:0][15:0] BASES = {`MV_BASE_LOW, `MV_BASE_LOW, `MV_BASE_REG3};

    logic [2:0][7:0]  code_r;
    logic [2:0][15:0] mv;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_reg
            // Store the written code as is, any value accepted
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    code_r[gi] <= RSTS[gi];
                end else if (req.wr && req.ptr == PTRS[gi]) begin
                    code_r[gi] <= req.wdata;
                end
            end

            // Code to voltage, linear in 0.1V steps
            code_to_mv #(
                .BASE_MV   (BASES[gi])
            ) u_conv (
                .clk_sys   (clk_sys),
                .code      (code_r[gi]),
                .volt_mv_r (mv[gi])
            );

            // Outside reset, a code moves only when its own pointer is written
            a_code_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
                !(req.wr && req.ptr == PTRS[gi]) |=> code_r[gi] == $past(code_r[gi]))
                else $error("code changed without a write");
        end
    endgenerate

    assign third_regulator_code  = code_r[0];
    assign fourth_regulator_code = code_r[1];
    assign fifth_regulator_code  = code_r[2];
    assign third_regulator_mv    = mv[0];
    assign fourth_regulator_mv   = mv[1];
    assign fifth_regulator_mv    = mv[2];

    // ****************************************************************
    // Read path
    // ****************************************************************
    // One cycle answer; unmapped pointers read zero, reserved bits read zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_r <= '{valid: 1'b0, data: `RST_READ_DATA};
        end else begin
            rsp_r.valid <= req.rd;
            case (req.ptr)
                `PTR_REG3_CODE:   rsp_r.data <= code_r[0];
                `PTR_REG4_CODE:   rsp_r.data <= code_r[1];
                `PTR_REG5_CODE:   rsp_r.data <= code_r[2];
                `PTR_SILICON_VER: rsp_r.data <= {6'h00, VERSION_CODE};
                default:          rsp_r.data <= `RST_READ_DATA;
            endcase
        end
    end

    // ****************************************************************
    // Checks: reset values
    // ****************************************************************
    // Third code comes out of reset at its fixed value
    a_reg3_reset: assert property (@(posedge clk_sys)
        sys_rst |=> third_regulator_code == `RST_REG3_CODE)
        else $error("third code not at reset value");

    // Fourth code comes out of reset at the variant value
    a_reg4_reset: assert property (@(posedge clk_sys)
        sys_rst |=> fourth_regulator_code == REG4_RESET)
        else $error("fourth code not at reset value");

    // Fifth code comes out of reset at the variant value
    a_reg5_reset: assert property (@(posedge clk_sys)
        sys_rst |=> fifth_regulator_code == REG5_RESET)
        else $error("fifth code not at reset value");

    // Voltages trail the codes by one edge, so two reset edges are needed
    a_reg3_reset_mv: assert property (@(posedge clk_sys)
        sys_rst ##1 sys_rst |=> third_regulator_mv ==
            16'(`MV_BASE_REG3 + 16'({8'h00, `RST_REG3_CODE} * `MV_STEP)))
        else $error("third voltage wrong after reset");

    a_reg5_reset_mv: assert property (@(posedge clk_sys)
        sys_rst ##1 sys_rst |=> fifth_regulator_mv ==
            16'(`MV_BASE_LOW + 16'({8'h00, REG5_RESET} * `MV_STEP)))
        else $error("fifth voltage wrong after reset");

    // ****************************************************************
    // Checks: code to voltage
    // ****************************************************************
    // Each voltage follows the code that stood one edge earlier
    a_reg3_voltage: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) |-> third_regulator_mv ==
            16'(`MV_BASE_REG3 + 16'({8'h00, $past(third_regulator_code)} * `MV_STEP)))
        else $error("third voltage does not follow its code");

    a_reg4_voltage: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) |-> fourth_regulator_mv ==
            16'(`MV_BASE_LOW + 16'({8'h00, $past(fourth_regulator_code)} * `MV_STEP)))
        else $error("fourth voltage does not follow its code");

    a_reg5_voltage: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) |-> fifth_regulator_mv ==
            16'(`MV_BASE_LOW + 16'({8'h00, $past(fifth_regulator_code)} * `MV_STEP)))
        else $error("fifth voltage does not follow its code");

    // ****************************************************************
    // Checks: writes
    // ****************************************************************
    // A written code lands at the taking edge, its voltage one edge later
    a_write_stores: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_REG4_CODE |=>
            fourth_regulator_code == $past(req.wdata) ##1 fourth_regulator_mv ==
            16'(`MV_BASE_LOW + 16'({8'h00, $past(req.wdata, 2)} * `MV_STEP)))
        else $error("fourth code write lost");

    // Third and fifth codes take the written data as is
    a_reg3_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_REG3_CODE |=> third_regulator_code == $past(req.wdata))
        else $error("third code write lost");

    a_reg5_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_REG5_CODE |=> fifth_regulator_code == $past(req.wdata))
        else $error("fifth code write lost");

    // The version pointer takes no write and disturbs no code
    a_version_readonly: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_SILICON_VER |=>
            third_regulator_code == $past(third_regulator_code) &&
            fourth_regulator_code == $past(fourth_regulator_code) &&
            fifth_regulator_code == $past(fifth_regulator_code))
        else $error("version write changed a code");

    // ****************************************************************
    // Checks: reads
    // ****************************************************************
    // Read answer pulses exactly one cycle after each read strobe
    a_read_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd |=> rsp_r.valid)
        else $error("read answer missing");

    a_valid_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !req.rd |=> !rsp_r.valid)
        else $error("read answer without a read");

    // Read data is the code as it stood at the taking edge
    a_read_reg3: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_REG3_CODE |=>
            rsp_r.data == $past(third_regulator_code))
        else $error("third code read back wrong");

    a_read_reg4: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_REG4_CODE |=>
            rsp_r.data == $past(fourth_regulator_code))
        else $error("fourth code read back wrong");

    a_read_back: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_REG5_CODE |=>
            rsp_r.valid && rsp_r.data == $past(fifth_regulator_code))
        else $error("fifth code read back wrong");

    // Version reads give the wired code and zero reserved bits
    a_version_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_SILICON_VER |=>
            rsp_r.data[`VER_CODE_MSB:`VER_CODE_LSB] == VERSION_CODE)
        else $error("version code wrong");

    a_version_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_SILICON_VER |=> rsp_r.data[7:2] == 6'h00)
        else $error("version reserved bits not zero");

    // ****************************************************************
    // Coverage of the main scenarios
    // ****************************************************************
    c_write_fifth_top: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_REG5_CODE && req.wdata == `TOP_CODE_LOW);
    c_read_version: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == `PTR_SILICON_VER);
    c_write_then_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.ptr == `PTR_REG3_CODE ##[1:2] req.rd && req.ptr == `PTR_REG3_CODE);
    c_read_unmapped: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.ptr == 8'h0a);
    c_mid_reset: cover property (@(posedge clk_sys)
        !sys_rst ##1 sys_rst);

endmodule

// [test/host_model.sv]
// Host model issuing register requests to the code bank
`timescale 1ns/1ps

module host_model (
    // Clock
    input  wire logic                   clk_sys,
    // Request out, answer in
    output ldo_regs_pkg::reg_req_t      req,
    input  wire ldo_regs_pkg::reg_rsp_t rsp_r
);
    initial req = '0;

    // One request for one cycle, answer taken in the cycle after the taking edge
    task automatic access(input logic w, input logic r, input logic [7:0] p,
                          input logic [7:0] d, output logic [8:0] got);
        @(posedge clk_sys);
        req <= '{wr: w, rd: r, ptr: p, wdata: d};
        @(posedge clk_sys);
        req <= '0;
        #1;
        got = {rsp_r.valid, rsp_r.data};
    endtask
endmodule

// [test/test_ldo_voltage_and_version_regs.sv]
// Self-checking bench for the regulator code and version registers
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module test_ldo_voltage_and_version_regs;
    localparam logic [7:0] R4_RST = 8'h19;
    localparam logic [7:0] R5_RST = 8'h14;
    localparam logic [1:0] VER    = 2'h3;    // Arbitrary value
    logic                   clk_sys;
    logic                   sys_rst;
    ldo_regs_pkg::reg_req_t req;
    ldo_regs_pkg::reg_rsp_t rsp_r;
    logic [7:0]             code3, code4, code5;
    logic [15:0]            mv3, mv4, mv5;
    logic [31:0]            lfsr;
    logic [8:0]             got;
    logic [7:0]             exp_code [3];
    logic [7:0]             d;
    int                     n_mismatch;
    int                     compares;
    int                     i;

    ldo_voltage_and_version_regs #(.REG4_RESET(R4_RST), .REG5_RESET(R5_RST),
        .VERSION_CODE(VER)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
        .rsp_r(rsp_r), .third_regulator_code(code3), .fourth_regulator_code(code4),
        .fifth_regulator_code(code5), .third_regulator_mv(mv3),
        .fourth_regulator_mv(mv4), .fifth_regulator_mv(mv5));
    host_model host (.clk_sys(clk_sys), .req(req), .rsp_r(rsp_r));

    // Pointer, live code and expected millivolts per register index
    function automatic logic [7:0] ptr(int k);
        return k == 0 ? `PTR_REG3_CODE : (k == 1 ? `PTR_REG4_CODE : `PTR_REG5_CODE);
    endfunction
    function automatic logic [7:0] cur_code(int k);
        return k == 0 ? code3 : (k == 1 ? code4 : code5);
    endfunction
    function automatic logic [15:0] cur_mv(int k);
        return k == 0 ? mv3 : (k == 1 ? mv4 : mv5);
    endfunction
    function automatic logic [15:0] exp_mv(int k, logic [7:0] c);
        return (k == 0 ? `MV_BASE_REG3 : `MV_BASE_LOW) + `MV_STEP * {8'h00, c};
    endfunction
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Read back every code register and compare codes and voltages
    task automatic check_all();
        for (int k = 0; k < 3; k++) begin
            host.access(1'b0, 1'b1, ptr(k), 8'h00, got);
            chk(16'(got), {7'h00, 1'b1, exp_code[k]});
            chk(16'(cur_code(k)), 16'(exp_code[k]));
            chk(cur_mv(k), exp_mv(k, exp_code[k]));
        end
    endtask

    task automatic put(int k, logic [7:0] v);
        host.access(1'b1, 1'b0, ptr(k), v, got);
        chk(16'(got[8]), 16'h0000);
        exp_code[k] = v;
        check_all();
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence: reset values, version, refused writes, corners, random codes
    initial begin
        sys_rst = 1'b1;
        n_mismatch = 0;
        compares = 0;
        lfsr = 32'h365a;
        exp_code = '{`RST_REG3_CODE, R4_RST, R5_RST};
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_all();
        for (int n = 0; n < 2; n++) begin
            host.access(1'b0, 1'b1, `PTR_SILICON_VER, 8'h00, got);
            chk(16'(got[8]), 16'h0001);
            chk(16'(got[1:0]), 16'(VER));
            host.access(1'b1, 1'b0, `PTR_SILICON_VER, 8'hfc, got);
            host.access(1'b1, 1'b0, 8'h0a, 8'hff, got);
        end
        host.access(1'b0, 1'b1, 8'h0a, 8'h00, got);
        chk(16'(got), 16'h0100);
        check_all();
        for (i = 0; i < 3; i++) begin
            put(i, 8'h00);
            put(i, i == 0 ? `TOP_CODE_REG3 : `TOP_CODE_LOW);
        end
        repeat (24) begin
            lfsr = lfsr_next(lfsr);
            i = int'(lfsr[1:0]) % 3;
            d = lfsr[15:8];
            if (i == 2) begin
                d = d % 8'h1a;
            end
            put(i, d);
        end
        // Mid-run reset must bring back the reset codes and voltages
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        exp_code = '{`RST_REG3_CODE, R4_RST, R5_RST};
        check_all();
        report_and_stop();
    end
endmodule
